// *** verilog/frm_consts.vh ***
/*
  Constants of the flash command host: register offsets, field positions,
  command codes, operation codes and pin timing counts.
  Assumes a 200 MHz clock (5 ns period); included by bare name.
*/
`ifndef FRM_CONSTS_VH
`define FRM_CONSTS_VH

// --------------------------------------------------
// Clock and pin timing
// --------------------------------------------------
`define FRM_CLK_PERIOD_NS  5
`define FRM_T_WP_NS        50
`define FRM_T_ACC_NS       80
`define FRM_T_RST_LOW_NS   100
`define FRM_T_RST_REC_NS   150
// Cycle counts: each ns figure above over the 5 ns period, sized for 8-bit counters
`define FRM_WP_CYC    8'h0A
`define FRM_ACC_CYC   8'h10
`define FRM_RLO_CYC   8'h14
`define FRM_RREC_CYC  8'h1E

// --------------------------------------------------
// Widths
// --------------------------------------------------
`define FRM_AW  22
`define FRM_DW  16

// --------------------------------------------------
// Device command codes
// --------------------------------------------------
`define FRM_CMD_READ_ARRAY   8'hFF
`define FRM_CMD_READ_ID      8'h90
`define FRM_CMD_QUERY        8'h98
`define FRM_CMD_READ_STATUS  8'h70
`define FRM_CMD_CLEAR_STATUS 8'h50
`define FRM_CMD_PROG_SETUP   8'h40
`define FRM_CMD_PROG_ALT     8'h10

// --------------------------------------------------
// Device status bits
// --------------------------------------------------
`define FRM_SR_READY      7
`define FRM_SR_PROG_FAIL  4
`define FRM_SR_SUPPLY     3
`define FRM_SR_LOCKED     1

// --------------------------------------------------
// Host register offsets
// --------------------------------------------------
`define FRM_REG_CTRL    8'h00
`define FRM_REG_ADDR    8'h04
`define FRM_REG_WDATA   8'h08
`define FRM_REG_RDATA   8'h0C
`define FRM_REG_STATUS  8'h10

// CTRL fields
`define FRM_CTRL_OP_LSB  0
`define FRM_CTRL_OP_MSB  2
`define FRM_CTRL_ALT     3

// STATUS fields
`define FRM_ST_BUSY       0
`define FRM_ST_DONE       1
`define FRM_ST_ARRAY      2
`define FRM_ST_SR_LSB     8
`define FRM_ST_SR_MSB     15
`define FRM_ST_PROG_FAIL  16
`define FRM_ST_SUPPLY     17
`define FRM_ST_LOCKED     18

// --------------------------------------------------
// Operation codes
// --------------------------------------------------
`define FRM_OP_READ     3'h0
`define FRM_OP_ID       3'h1
`define FRM_OP_QUERY    3'h2
`define FRM_OP_STATUS   3'h3
`define FRM_OP_CLEAR    3'h4
`define FRM_OP_PROG     3'h5
`define FRM_OP_RESET    3'h6
`define FRM_OP_ARRAY    3'h7

`endif

// *** verilog/frm_bus_cycle.v ***
/*
  One asynchronous flash bus cycle, read or write, on the chip select,
  output enable and write strobe pins with address and data bus.
  Assumes a start pulse only while idle; pins are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frm_consts.vh"

module frm_bus_cycle (
  input  wire                 clock,
  input  wire                 reset,
  input  wire                 start,
  input  wire                 write,
  input  wire [`FRM_AW-1:0]   addr_in,
  input  wire [`FRM_DW-1:0]   data_in,
  output reg                  done,
  output reg  [`FRM_DW-1:0]   rdata,
  output reg                  ce_n,
  output reg                  oe_n,
  output reg                  we_n,
  output reg  [`FRM_AW-1:0]   addr,
  output reg  [`FRM_DW-1:0]   dq_out,
  output reg                  dq_oe,
  input  wire [`FRM_DW-1:0]   dq_in
);

  // --------------------------------------------------
  // States
  // --------------------------------------------------
  localparam [3:0] S_IDLE   = 4'h1;
  localparam [3:0] S_SETUP  = 4'h2;
  localparam [3:0] S_STROBE = 4'h4;
  localparam [3:0] S_HOLD   = 4'h8;
  localparam [7:0] WP_CYC   = `FRM_WP_CYC;
  localparam [7:0] ACC_CYC  = `FRM_ACC_CYC;

  reg [3:0] state_r;
  reg [7:0] cnt_r;
  reg       wr_r;

  // --------------------------------------------------
  // Sequencer
  // --------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      done    <= 1'b0;
      rdata   <= 16'h0000;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      addr    <= {`FRM_AW{1'b0}};
      dq_out  <= 16'h0000;
      dq_oe   <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            wr_r    <= write;
            addr    <= addr_in;
            dq_out  <= data_in;
            dq_oe   <= write;
            ce_n    <= 1'b0;
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (wr_r) begin
            we_n  <= 1'b0;
            cnt_r <= WP_CYC;
          end else begin
            oe_n  <= 1'b0;
            cnt_r <= ACC_CYC;
          end
          state_r <= S_STROBE;
        end
        S_STROBE: begin
          if (cnt_r <= 8'h01) begin
            // Write strobe rises before chip select: device latches here
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_r) begin
              rdata <= dq_in;
            end
            state_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_HOLD: begin
          // Chip select always returns high so every read is freshly latched
          ce_n    <= 1'b1;
          dq_oe   <= 1'b0;
          done    <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** verilog/frm_host.v ***
/*
  Flash command host: takes orders over AHB-Lite and drives a parallel
  NOR flash through its pins for read, identifier, query, status, clear,
  program and reset operations.
  Assumes one AHB-Lite master, word transfers, flash pins synchronous.
*/
// Added by the designer: the AHB-Lite register port and the address map.
// Behaviour
// - Host writes 0xFF before array reads when device left read-array mode.
// - Host toggles select between status reads; completion shows only when fresh.
// - Program is setup write 0x40, or 0x10 with CTRL ALT set, then a write of address and data.
// - After programming, host checks and clears status, returns to array mode.
`timescale 1ns/1ps
`default_nettype none
`include "frm_consts.vh"

module frm_host (
  input  wire                 clock,
  input  wire                 reset,
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output wire                 hreadyout,
  output wire                 hresp,
  output reg  [31:0]          hrdata,
  output wire                 ce_n,
  output wire                 oe_n,
  output wire                 we_n,
  output reg                  power_down_reset_n,
  output wire [`FRM_AW-1:0]   addr,
  output wire [`FRM_DW-1:0]   dq_out,
  output wire                 dq_oe,
  input  wire [`FRM_DW-1:0]   dq_in
);

  // --------------------------------------------------
  // States
  // --------------------------------------------------
  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_RLO   = 9'h002;
  localparam [8:0] S_RREC  = 9'h004;
  localparam [8:0] S_CMD   = 9'h008;
  localparam [8:0] S_ACC   = 9'h010;
  localparam [8:0] S_POLL  = 9'h020;
  localparam [8:0] S_CLR   = 9'h040;
  localparam [8:0] S_ARR   = 9'h080;
  localparam [8:0] S_FIN   = 9'h100;
  localparam [7:0] RLO_CYC  = `FRM_RLO_CYC;
  localparam [7:0] RREC_CYC = `FRM_RREC_CYC;

  reg  [8:0]          state_r;
  reg  [8:0]          state_nxt;
  reg  [2:0]          op_r;
  reg                 alt_r;
  reg  [`FRM_AW-1:0]  addr_r;
  reg  [`FRM_DW-1:0]  wdata_r;
  reg  [`FRM_DW-1:0]  rdata_r;
  reg  [7:0]          sr_r;
  reg                 busy_r;
  reg                 done_r;
  reg                 array_r;
  reg                 pend_r;
  reg  [7:0]          cnt_r;
  reg                 ph_wr_r;
  reg  [7:0]          ph_addr_r;

  wire                bc_done;
  wire [`FRM_DW-1:0]  bc_rdata;
  reg                 bc_write;
  reg  [`FRM_DW-1:0]  bc_data;
  reg  [`FRM_AW-1:0]  bc_addr;
  wire                in_cycle;
  wire                bc_start;
  wire                take;
  wire                start_op;

  // --------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & hready & htrans[1];
  assign start_op  = ph_wr_r & (ph_addr_r == `FRM_REG_CTRL) & ~busy_r;

  function [31:0] frm_read_mux;
    input [7:0] a;
    begin
      case (a)
        `FRM_REG_CTRL:   frm_read_mux = {28'h0000000, alt_r, op_r};
        `FRM_REG_ADDR:   frm_read_mux = {10'h000, addr_r};
        `FRM_REG_WDATA:  frm_read_mux = {16'h0000, wdata_r};
        `FRM_REG_RDATA:  frm_read_mux = {16'h0000, rdata_r};
        `FRM_REG_STATUS: frm_read_mux = {13'h0000, sr_r[`FRM_SR_LOCKED], sr_r[`FRM_SR_SUPPLY],
                                         sr_r[`FRM_SR_PROG_FAIL], sr_r, 5'h00, array_r, done_r, busy_r};
        default:         frm_read_mux = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
      hrdata    <= 32'h00000000;
      alt_r     <= 1'b0;
      addr_r    <= {`FRM_AW{1'b0}};
      wdata_r   <= 16'h0000;
    end else begin
      ph_wr_r <= take & hwrite;
      if (take) begin
        ph_addr_r <= haddr[7:0];
        hrdata    <= frm_read_mux(haddr[7:0]);
      end
      if (ph_wr_r) begin
        case (ph_addr_r)
          `FRM_REG_CTRL: begin
            if (!busy_r) begin
              alt_r <= hwdata[`FRM_CTRL_ALT];
            end
          end
          `FRM_REG_ADDR:  addr_r  <= hwdata[`FRM_AW-1:0];
          `FRM_REG_WDATA: wdata_r <= hwdata[`FRM_DW-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // --------------------------------------------------
  // Bus cycle requests
  // --------------------------------------------------
  assign in_cycle = (state_r == S_CMD) | (state_r == S_ACC) | (state_r == S_POLL) |
                    (state_r == S_CLR) | (state_r == S_ARR);
  assign bc_start = in_cycle & ~pend_r;

  always @* begin
    bc_write = 1'b1;
    bc_addr  = addr_r;
    bc_data  = {8'h00, `FRM_CMD_READ_ARRAY};
    case (state_r)
      S_CMD: begin
        case (op_r)
          `FRM_OP_ID:     bc_data = {8'h00, `FRM_CMD_READ_ID};
          `FRM_OP_QUERY:  bc_data = {8'h00, `FRM_CMD_QUERY};
          `FRM_OP_STATUS: bc_data = {8'h00, `FRM_CMD_READ_STATUS};
          `FRM_OP_CLEAR:  bc_data = {8'h00, `FRM_CMD_CLEAR_STATUS};
          `FRM_OP_PROG:   bc_data = {8'h00, alt_r ? `FRM_CMD_PROG_ALT : `FRM_CMD_PROG_SETUP};
          default:        bc_data = {8'h00, `FRM_CMD_READ_ARRAY};
        endcase
      end
      S_ACC: begin
        bc_write = (op_r == `FRM_OP_PROG);
        bc_data  = wdata_r;
      end
      S_POLL: begin
        bc_write = 1'b0;
      end
      S_CLR: begin
        bc_data = {8'h00, `FRM_CMD_CLEAR_STATUS};
      end
      default: begin
      end
    endcase
  end

  // --------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (start_op) begin
          case (hwdata[`FRM_CTRL_OP_MSB:`FRM_CTRL_OP_LSB])
            `FRM_OP_RESET: state_nxt = S_RLO;
            `FRM_OP_READ:  state_nxt = array_r ? S_ACC : S_CMD;
            default:       state_nxt = S_CMD;
          endcase
        end
      end
      S_RLO:  state_nxt = (cnt_r <= 8'h01) ? S_RREC : S_RLO;
      S_RREC: state_nxt = (cnt_r <= 8'h01) ? S_FIN : S_RREC;
      S_CMD: begin
        if (bc_done) begin
          state_nxt = (op_r == `FRM_OP_CLEAR || op_r == `FRM_OP_ARRAY) ? S_FIN : S_ACC;
        end
      end
      S_ACC: begin
        if (bc_done) begin
          state_nxt = (op_r == `FRM_OP_PROG) ? S_POLL : S_FIN;
        end
      end
      S_POLL: begin
        // Only status reads during programming; each read is a fresh cycle
        if (bc_done && bc_rdata[`FRM_SR_READY]) begin
          state_nxt = S_CLR;
        end
      end
      S_CLR:   state_nxt = bc_done ? S_ARR : S_CLR;
      S_ARR:   state_nxt = bc_done ? S_FIN : S_ARR;
      S_FIN:   state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r            <= S_IDLE;
      op_r               <= `FRM_OP_READ;
      busy_r             <= 1'b0;
      done_r             <= 1'b0;
      array_r            <= 1'b1;
      pend_r             <= 1'b0;
      cnt_r              <= 8'h00;
      rdata_r            <= 16'h0000;
      sr_r               <= 8'h00;
      power_down_reset_n <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (bc_start) begin
        pend_r <= 1'b1;
      end else if (bc_done) begin
        pend_r <= 1'b0;
      end
      if (state_r == S_IDLE && start_op) begin
        op_r   <= hwdata[`FRM_CTRL_OP_MSB:`FRM_CTRL_OP_LSB];
        busy_r <= 1'b1;
        done_r <= 1'b0;
        cnt_r  <= RLO_CYC;
        if (hwdata[`FRM_CTRL_OP_MSB:`FRM_CTRL_OP_LSB] == `FRM_OP_RESET) begin
          power_down_reset_n <= 1'b0;
        end
      end
      if (state_r == S_RLO) begin
        if (cnt_r <= 8'h01) begin
          power_down_reset_n <= 1'b1;
          cnt_r              <= RREC_CYC;
          sr_r               <= 8'h80;
          array_r            <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
      if (state_r == S_RREC && cnt_r > 8'h01) begin
        cnt_r <= cnt_r - 8'h01;
      end
      if (state_r == S_CMD && bc_done) begin
        array_r <= (op_r == `FRM_OP_READ) | (op_r == `FRM_OP_ARRAY) |
                   (array_r & (op_r == `FRM_OP_CLEAR));
        if (op_r == `FRM_OP_CLEAR) begin
          sr_r <= sr_r & 8'h80;
        end
      end
      if (state_r == S_ACC && bc_done) begin
        if (op_r != `FRM_OP_PROG) begin
          rdata_r <= bc_rdata;
        end else begin
          array_r <= 1'b0;
        end
        if (op_r == `FRM_OP_STATUS) begin
          sr_r <= bc_rdata[7:0];
        end
      end
      if (state_r == S_POLL && bc_done) begin
        rdata_r <= bc_rdata;
        // Keep program outcome: fail, supply, locked-block flags
        sr_r    <= bc_rdata[7:0];
      end
      if (state_r == S_ARR && bc_done) begin
        array_r <= 1'b1;
      end
      if (state_r == S_FIN) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------
  // Pin cycle engine
  // --------------------------------------------------
  frm_bus_cycle u_cycle (
    .clock   (clock),
    .reset   (reset),
    .start   (bc_start),
    .write   (bc_write),
    .addr_in (bc_addr),
    .data_in (bc_data),
    .done    (bc_done),
    .rdata   (bc_rdata),
    .ce_n    (ce_n),
    .oe_n    (oe_n),
    .we_n    (we_n),
    .addr    (addr),
    .dq_out  (dq_out),
    .dq_oe   (dq_oe),
    .dq_in   (dq_in)
  );

endmodule
`default_nettype wire

// *** verif/frm_host_monitor.sv ***
/*
  Checker of the flash host's pin timing, bound to frm_host.
  Assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frm_consts.vh"

module frm_host_monitor (
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               ce_n,
  input wire logic               oe_n,
  input wire logic               we_n,
  input wire logic               power_down_reset_n,
  input wire logic [`FRM_AW-1:0] addr,
  input wire logic [`FRM_DW-1:0] dq_out,
  input wire logic               dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_no_drive_clash: assert property (!(!oe_n && (!we_n || dq_oe)))
    else $error("read enable overlaps a host drive");
  a_read_fresh: assert property ($rose(oe_n) |=> ce_n)
    else $error("select not released after a read");
  a_write_pulse: assert property ($fell(we_n) |-> (!we_n)[*8] ##1 !we_n ##1 !we_n ##1 (we_n && !ce_n))
    else $error("write strobe width wrong");
  a_write_hold: assert property (!we_n && $past(!we_n) |-> $stable(addr) && $stable(dq_out) && dq_oe)
    else $error("address or data moved under the strobe");
  a_write_setup: assert property ($fell(we_n) |-> $past(!ce_n) && $past(dq_oe))
    else $error("strobe fell before select and data");
  a_write_release: assert property ($rose(we_n) |=> ce_n && !dq_oe)
    else $error("write cycle not closed");
  a_read_access: assert property ($fell(oe_n) |-> !ce_n throughout (##15 !oe_n ##1 oe_n))
    else $error("read access length wrong");
  a_reset_pulse: assert property ($fell(power_down_reset_n) |-> ##19 !power_down_reset_n ##1 power_down_reset_n)
    else $error("device reset pulse length wrong");
  a_reset_quiet: assert property (!power_down_reset_n |-> ce_n && oe_n && we_n)
    else $error("bus cycle during device reset");
endmodule
`default_nettype wire

// *** verif/frm_flash_model.sv ***
/*
  Behavioural parallel flash: read modes, status register, program.
  Assumes the host's pins; knobs for supply fault, unlock and failure.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frm_consts.vh"

module frm_flash_model #(
  parameter logic [15:0] MAKER_CODE  = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5A3C, // Arbitrary value
  parameter logic [15:0] PLOCK_WORD  = 16'h0002,
  parameter logic [15:0] PREG_BASE   = 16'hC000,
  parameter logic [15:0] QUERY_WORD  = 16'h0051,
  parameter int          PROG_NS     = 300
) (
  input  wire logic               ce_n,
  input  wire logic               oe_n,
  input  wire logic               we_n,
  input  wire logic               power_down_reset_n,
  input  wire logic [`FRM_AW-1:0] addr,
  input  wire logic [`FRM_DW-1:0] dq_out,
  input  wire logic               dq_oe,
  input  wire logic               vpp_ok,
  input  wire logic               unlock,
  input  wire logic               fail_inj,
  output wire logic [`FRM_DW-1:0] dq_in
);
  localparam logic [1:0] M_ARR = 2'd0, M_ID = 2'd1, M_QRY = 2'd2, M_ST = 2'd3;
  logic [1:0]  mode;
  logic [7:0]  sr, sr_lat;
  logic        locked, setup, busy, drive;
  logic [15:0] mem [int];
  logic [15:0] rv, last, pd;
  logic [21:0] pa;
  event        go;

  function automatic logic [15:0] rd(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  task automatic wipe;
    sr = 8'h80;
    mode = M_ARR;
    locked = 1'b1;
    setup = 1'b0;
    busy = 1'b0;
  endtask

  initial begin
    wipe;
    sr_lat = 8'h80;
    last = 16'h0000;
  end
  always @(negedge power_down_reset_n) wipe;
  always @(posedge power_down_reset_n) mode = M_ARR;
  always @(posedge unlock) locked = 1'b0;

  // Command capture on the first rising strobe or select
  always @(posedge we_n or posedge ce_n) begin
    if (power_down_reset_n && oe_n && dq_oe && (!ce_n || !we_n)) begin
      if (busy) begin
        if (dq_out[7:0] == 8'h70) mode = M_ST;
      end else if (setup) begin
        setup = 1'b0;
        pa = addr;
        pd = dq_out;
        if (!vpp_ok) sr[3] = 1'b1;
        else if (locked) sr[1] = 1'b1;
        else begin
          sr[7] = 1'b0;
          busy = 1'b1;
          -> go;
        end
      end else begin
        case (dq_out[7:0])
          8'hFF: mode = M_ARR;
          8'h90: mode = M_ID;
          8'h98: mode = M_QRY;
          8'h70: mode = M_ST;
          8'h50: sr = sr & 8'hC5;
          8'h40, 8'h10: begin
            setup = 1'b1;
            mode = M_ST;
          end
          default: ;
        endcase
      end
    end
  end

  always begin
    @(go);
    #(PROG_NS);
    if (fail_inj) sr[4] = 1'b1;
    else mem[pa] = rd(pa) & pd;
    sr[7] = 1'b1;
    busy = 1'b0;
  end

  always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) sr_lat = sr;

  always @* begin
    case (mode)
      M_ARR: rv = rd(addr);
      M_ID: begin
        if (addr[7:0] == 8'h00) rv = MAKER_CODE;
        else if (addr[7:0] == 8'h01) rv = DEVICE_CODE;
        else if (addr[7:0] == 8'h02) rv = {14'h0000, 1'b0, locked};
        else if (addr[7:0] == 8'h80) rv = PLOCK_WORD;
        else if (addr[7:0] >= 8'h81 && addr[7:0] <= 8'h88) rv = PREG_BASE + {8'h00, addr[7:0] - 8'h80};
        else rv = 16'h0000;
      end
      M_QRY: rv = (addr[7:0] == 8'h10) ? QUERY_WORD : 16'h0000;
      default: rv = {8'h00, sr_lat};
    endcase
  end

  assign drive = !ce_n && !oe_n && we_n && power_down_reset_n;
  always @(rv or drive) if (drive) last = rv;
  assign dq_in = drive ? rv : ~last;
endmodule
`default_nettype wire

// *** verif/tb_frm_host.sv ***
/*
  Self-checking bench of the flash host: AHB-Lite master tasks, flash
  model on the pins, one task per scenario.
  Assumes frm_host, frm_flash_model and frm_host_monitor are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frm_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_frm_host;
  localparam logic [15:0] MK = 16'h00A5; // Arbitrary value
  localparam logic [15:0] DV = 16'h5A3C; // Arbitrary value
  localparam logic [15:0] PL = 16'h0002;
  localparam logic [15:0] PR = 16'hC000;
  logic        clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        vpp_ok = 1'b1, unlock = 1'b0, fail_inj = 1'b0;
  wire         hreadyout, hresp, ce_n, oe_n, we_n, pdr_n, dq_oe;
  wire  [31:0] hrdata;
  wire  [21:0] addr;
  wire  [15:0] dq_out, dq_in;
  int          n_mismatch = 0, total_checks = 0;

  always #2.5 clock = ~clock;

  frm_host i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .power_down_reset_n(pdr_n), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));
  frm_flash_model #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .PLOCK_WORD(PL), .PREG_BASE(PR)) i_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .power_down_reset_n(pdr_n), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .vpp_ok(vpp_ok), .unlock(unlock), .fail_inj(fail_inj), .dq_in(dq_in));

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask

  task automatic op(input logic [3:0] c, output logic [31:0] st);
    logic [31:0] r;
    ahb(1'b1, `FRM_REG_CTRL, {28'h0, c}, r);
    for (int k = 0; k < 500; k++) begin
      ahb(1'b0, `FRM_REG_STATUS, 32'h0, st);
      if (st[1:0] === 2'b10) break;
    end
    `CHK(st[1:0], 2'b10)
  endtask

  task automatic fread(input logic [2:0] o, input logic [21:0] a, output logic [15:0] v);
    logic [31:0] r;
    ahb(1'b1, `FRM_REG_ADDR, {10'h000, a}, r);
    op({1'b0, o}, r);
    ahb(1'b0, `FRM_REG_RDATA, 32'h0, r);
    v = r[15:0];
  endtask

  task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic alt, output logic [31:0] st);
    logic [31:0] r;
    ahb(1'b1, `FRM_REG_ADDR, {10'h000, a}, r);
    ahb(1'b1, `FRM_REG_WDATA, {16'h0000, d}, r);
    op({alt, `FRM_OP_PROG}, st);
  endtask

  task automatic t_boot;
    logic [31:0] r;
    logic [15:0] v;
    ahb(1'b0, `FRM_REG_STATUS, 32'h0, r);
    `CHK(r[2:0], 3'b100)
    ahb(1'b0, 8'h20, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    fread(`FRM_OP_READ, 22'h000123, v);
    `CHK(v, 16'hFFFF)
    fread(`FRM_OP_ID, 22'h000002, v);
    `CHK(v, 16'h0001)
  endtask

  task automatic t_ident;
    logic [7:0]  offs [5] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'h88};
    logic [15:0] exps [5] = '{MK, DV, PL, PR + 16'h0001, PR + 16'h0008};
    logic [31:0] st;
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      fread(`FRM_OP_ID, {14'h0060, offs[i]}, v);
      `CHK(v, exps[i])
    end
    op({1'b0, `FRM_OP_ARRAY}, st);
    `CHK(st[2], 1'b1)
    fread(`FRM_OP_READ, 22'h000060, v);
    `CHK(v, 16'hFFFF)
  endtask

  task automatic t_query;
    logic [15:0] v;
    fread(`FRM_OP_QUERY, 22'h000010, v);
    `CHK(v, 16'h0051)
    fread(`FRM_OP_READ, 22'h000010, v);
    `CHK(v, 16'hFFFF)
  endtask

  task automatic t_locked;
    logic [31:0] st;
    logic [15:0] v;
    prog(22'h000200, 16'h1234, 1'b0, st);
    `CHK(st[18:16], 3'b100)
    `CHK(st[15:8], 8'h82)
    fread(`FRM_OP_READ, 22'h000200, v);
    `CHK(v, 16'hFFFF)
  endtask

  task automatic t_prog;
    logic [31:0] st;
    logic [15:0] v;
    unlock <= 1'b1;
    prog(22'h000300, 16'h12F4, 1'b0, st);
    `CHK(st[18:8], 11'h080)
    fread(`FRM_OP_READ, 22'h000300, v);
    `CHK(v, 16'h12F4)
    prog(22'h000300, 16'hFFF0, 1'b1, st);
    `CHK(st[18:8], 11'h080)
    fread(`FRM_OP_READ, 22'h000300, v);
    `CHK(v, 16'h12F0)
  endtask

  task automatic t_faults;
    logic [31:0] st;
    logic [15:0] v;
    vpp_ok <= 1'b0;
    prog(22'h000400, 16'h0000, 1'b0, st);
    `CHK(st[18:8], 11'h288)
    vpp_ok <= 1'b1;
    fread(`FRM_OP_READ, 22'h000400, v);
    `CHK(v, 16'hFFFF)
    fail_inj <= 1'b1;
    prog(22'h000500, 16'h0F0F, 1'b0, st);
    `CHK(st[18:8], 11'h190)
    fail_inj <= 1'b0;
    fread(`FRM_OP_STATUS, 22'h000000, v);
    `CHK(v, 16'h0080)
  endtask

  task automatic t_reset_op;
    logic [31:0] st;
    logic [15:0] v;
    op({1'b0, `FRM_OP_CLEAR}, st);
    `CHK(st[18:8], 11'h080)
    op({1'b0, `FRM_OP_RESET}, st);
    `CHK(st[2], 1'b1)
    fread(`FRM_OP_ID, 22'h000002, v);
    `CHK(v, 16'h0001)
    fread(`FRM_OP_STATUS, 22'h000000, v);
    `CHK(v, 16'h0080)
  endtask

  task summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_boot;
    t_ident;
    t_query;
    t_locked;
    t_prog;
    t_faults;
    t_reset_op;
    summarize;
  end

  initial begin
    #200000;
    n_mismatch++;
    summarize;
  end
endmodule

bind frm_host frm_host_monitor i_mon (.clock(clock), .reset(reset), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .power_down_reset_n(power_down_reset_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire
